// ---- verilog/ussu_top.sv ----
// Purpose: Unsigned packed subtract, saturate and extend-add unit.
// Assumes: Operands arrive with a condition-pass qualifier each cycle.
// Notes:   Results are presented combinationally and also registered.
//
// Summary of operation
// - Saturate signed halves to chosen unsigned range.
// - Zero-extend saturated halves into matching destination halves.
// - Set sticky saturation on any committed clamp; only reset clears it.
// - Flag reserved indices on dual saturate.
// - Exchange: low sum, high difference truncated.
// - Exchange flags from sum carry and difference.
// - Dual-half subtract, truncated per half.
// - Dual-half flags pairwise on no borrow.
// - Quad-byte subtract, truncated per byte.
// - Per-byte flag set on no borrow.
// - Flag reserved indices on subtract forms.
// - Commit only when condition passes.
// - Rotate, take low byte, zero-extend, add.
// - Rotation amount is field times eight.
// - Select dual saturate from shift fields.
`default_nettype none
module ussu_top (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  issue_i,
  input  wire logic                  cond_pass_i,
  input  wire ussu_pkg::ussu_op_type op_i,
  input  wire logic [3:0]            dest_idx_i,
  input  wire logic [3:0]            first_operand_reg_index_i,
  input  wire logic [3:0]            second_operand_reg_index_i,
  input  wire logic [31:0]           first_value_i,
  input  wire logic [31:0]           second_value_i,
  input  wire logic [3:0]            sat_pos_i,
  input  wire logic [1:0]            rot_code_i,
  input  wire logic                  shift_type_i,
  input  wire logic [4:0]            shift_amt_i,
  input  wire logic                  packed_ext_i,
  output logic [31:0]                result_o,
  output logic [3:0]                 dest_idx_o,
  output logic                       dest_we_o,
  output logic [3:0]                 lane_greater_equal_flags_o,
  output logic                       ge_we_o,
  output logic                       sticky_saturation_flag_o,
  output logic                       unpred_o,
  output logic [31:0]                result_reg_o,
  output logic [3:0]                 ge_reg_o
);
  import ussu_pkg::*;

  ussu_lane_if lif ();
  ussu_op_type op_res;   // Resolved operation.
  logic        unpred;   // Reserved index in use.
  logic        commit;   // Instruction retires this cycle.
  logic [31:0] res_mux;  // Selected result.
  logic [3:0]  ge_mux;   // Selected flags.
  logic        ge_upd;   // Operation writes the flags.
  logic        q_hit;    // Operation saturated.
  logic        q_reg;    // Sticky saturation state.
  logic        q_next;
  logic [31:0] res_reg;
  logic [31:0] res_next;
  logic [3:0]  ge_reg;
  logic [3:0]  ge_next;

  //////////////////////////////////////////////////////////////////////
  // Decode and lane arithmetic.
  ussu_decode u_dec (
    .op_i         (op_i),
    .dest_idx_i   (dest_idx_i),
    .first_idx_i  (first_operand_reg_index_i),
    .second_idx_i (second_operand_reg_index_i),
    .shift_type_i (shift_type_i),
    .shift_amt_i  (shift_amt_i),
    .packed_ext_i (packed_ext_i),
    .op_o         (op_res),
    .unpred_o     (unpred)
  );

  assign lif.opa      = first_value_i;
  assign lif.opb      = second_value_i;
  assign lif.sat_pos  = sat_pos_i;
  assign lif.rot_code = rot_code_i;

  ussu_lanes u_lanes (
    .lif (lif.lane)
  );

  //////////////////////////////////////////////////////////////////////
  // Result select; a failed condition suppresses every write.
  always_comb begin
    commit = issue_i & cond_pass_i & (op_res != OP_NONE);
    ge_upd = 1'b0;
    q_hit  = 1'b0;
    ge_mux = ge_reg;
    case (op_res)
      OP_DUAL_HALF_SAT: begin
        res_mux = lif.sat_res;
        q_hit   = lif.sat_hit;
      end
      OP_XCHG_SUB_ADD: begin
        res_mux = lif.xsa_res;
        ge_mux  = lif.xsa_ge;
        ge_upd  = 1'b1;
      end
      OP_DUAL_HALF_SUB: begin
        res_mux = lif.sub16_res;
        ge_mux  = lif.sub16_ge;
        ge_upd  = 1'b1;
      end
      OP_QUAD_BYTE_SUB: begin
        res_mux = lif.sub8_res;
        ge_mux  = lif.sub8_ge;
        ge_upd  = 1'b1;
      end
      OP_ROT_EXT_ADD:
        res_mux = lif.ext_res;
      default:
        res_mux = RESULT_RST;
    endcase
    // Write enables leave with the result in one cycle.
    result_o  = res_mux;
    dest_idx_o = dest_idx_i;
    dest_we_o = commit;
    ge_we_o   = commit & ge_upd;
    lane_greater_equal_flags_o = ge_mux;
    unpred_o  = issue_i & unpred;
    // Sticky: only ever set, a miss leaves it alone.
    q_next   = q_reg | (commit & q_hit);
    res_next = commit ? res_mux : res_reg;
    ge_next  = (commit & ge_upd) ? ge_mux : ge_reg;
  end

  //////////////////////////////////////////////////////////////////////
  // Architectural copies of the last committed result and flags.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_reg   <= Q_RST;
      res_reg <= RESULT_RST;
      ge_reg  <= GE_RST;
    end else begin
      q_reg   <= q_next;
      res_reg <= res_next;
      ge_reg  <= ge_next;
    end
  end

  assign sticky_saturation_flag_o = q_reg;
  assign result_reg_o = res_reg;
  assign ge_reg_o     = ge_reg;

  //////////////////////////////////////////////////////////////////////
  // Checks.
  a_cond_blocks: assert property (@(posedge clk_i) disable iff (reset_i)
    !cond_pass_i |=> ($stable(res_reg) && $stable(ge_reg)
                      && $stable(q_reg)))
    else $error("state changed on failed condition");
  a_q_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    q_reg |=> q_reg)
    else $error("sticky saturation cleared");
  a_q_set: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_DUAL_HALF_SAT && lif.sat_hit) |=> q_reg)
    else $error("saturation not recorded");
  a_sub16_ge: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_DUAL_HALF_SUB) |=>
      ge_reg[1:0] == {2{$past(first_value_i[15:0])
                         >= $past(second_value_i[15:0])}})
    else $error("dual-half low flags wrong");
  a_sub8_res: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_QUAD_BYTE_SUB) |=>
      res_reg[15:8] == 8'($past(first_value_i[15:8])
                          - $past(second_value_i[15:8])))
    else $error("byte difference wrong");
  a_sub8_ge: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_QUAD_BYTE_SUB) |=>
      ge_reg[1] == ($past(first_value_i[15:8])
                    >= $past(second_value_i[15:8])))
    else $error("byte lane one flag wrong");
  a_xsa_res: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_XCHG_SUB_ADD) |=>
      res_reg[15:0] == 16'($past(first_value_i[15:0])
                           + $past(second_value_i[31:16])))
    else $error("exchange sum wrong");
  a_ext_add: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_ROT_EXT_ADD && rot_code_i == 2'b01) |=>
      res_reg == $past(first_value_i)
                 + {24'h00_0000, $past(second_value_i[15:8])})
    else $error("rotate extend add wrong");
  a_sat_range: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_DUAL_HALF_SAT) |->
      (32'(result_o[15:0]) < (32'h0000_0001 << sat_pos_i)))
    else $error("saturated half out of range");

  //////////////////////////////////////////////////////////////////////
  // Further checks, some built on named sequences for the exchange, subtract and saturate kinds.

  // An exchange subtract/add retiring at this edge.
  sequence s_retire_xsa;
    commit && op_res == OP_XCHG_SUB_ADD;
  endsequence

  // A dual-half subtract retiring at this edge.
  sequence s_retire_sub16;
    commit && op_res == OP_DUAL_HALF_SUB;
  endsequence

  // A quad-byte subtract retiring at this edge.
  sequence s_retire_sub8;
    commit && op_res == OP_QUAD_BYTE_SUB;
  endsequence

  // A dual-half saturate retiring at this edge.
  sequence s_retire_sat;
    commit && op_res == OP_DUAL_HALF_SAT;
  endsequence

  // The high half of the exchange form is the truncated difference.
  a_xsa_diff: assert property (@(posedge clk_i) disable iff (reset_i)
    s_retire_xsa |=>
      res_reg[31:16] == 16'($past(first_value_i[31:16])
                            - $past(second_value_i[15:0])))
    else $error("exchange difference wrong");

  // Exchange flags: carry out of the sum low, no borrow high.
  a_xsa_ge: assert property (@(posedge clk_i) disable iff (reset_i)
    s_retire_xsa |=>
      ge_reg == {{2{$past(first_value_i[31:16])
                    >= $past(second_value_i[15:0])}},
                 {2{(17'($past(first_value_i[15:0]))
                     + 17'($past(second_value_i[31:16])))
                    >= SUM_CARRY}}})
    else $error("exchange flags wrong");

  // Both halves of the dual-half difference, truncated.
  a_sub16_res: assert property (@(posedge clk_i) disable iff (reset_i)
    s_retire_sub16 |=>
      res_reg == {16'($past(first_value_i[31:16])
                      - $past(second_value_i[31:16])),
                  16'($past(first_value_i[15:0])
                      - $past(second_value_i[15:0]))})
    else $error("dual-half difference wrong");

  // The high lane drives the upper flag pair.
  a_sub16_hi: assert property (@(posedge clk_i) disable iff (reset_i)
    s_retire_sub16 |=>
      ge_reg[3:2] == {2{$past(first_value_i[31:16])
                        >= $past(second_value_i[31:16])}})
    else $error("dual-half high flags wrong");

  // The top byte lane and its flag bit.
  a_sub8_top: assert property (@(posedge clk_i) disable iff (reset_i)
    s_retire_sub8 |=>
      (res_reg[31:24] == 8'($past(first_value_i[31:24])
                            - $past(second_value_i[31:24])))
      && (ge_reg[3] == ($past(first_value_i[31:24])
                        >= $past(second_value_i[31:24]))))
    else $error("top byte lane wrong");

  // A negative high half clamps to zero.
  a_sat_neg: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_retire_sat and first_value_i[31]) |->
      result_o[31:16] == 16'h0000)
    else $error("negative half not clamped to zero");

  // The high half stays inside the chosen range as well.
  a_sat_hi: assert property (@(posedge clk_i) disable iff (reset_i)
    s_retire_sat |->
      (32'(result_o[31:16]) < (32'h0000_0001 << sat_pos_i)))
    else $error("high saturated half out of range");

  // No rotation: the plain low byte is added.
  a_ext_plain: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_ROT_EXT_ADD && rot_code_i == 2'b00) |=>
      res_reg == $past(first_value_i)
                 + {24'h00_0000, $past(second_value_i[7:0])})
    else $error("extend add without rotation wrong");

  // Largest rotation brings the top byte down.
  a_ext_top: assert property (@(posedge clk_i) disable iff (reset_i)
    (commit && op_res == OP_ROT_EXT_ADD && rot_code_i == 2'b11) |=>
      res_reg == $past(first_value_i)
                 + {24'h00_0000, $past(second_value_i[31:24])})
    else $error("rotate by three bytes wrong");

  // A failed condition raises no write enable at all.
  a_cond_we: assert property (@(posedge clk_i) disable iff (reset_i)
    !cond_pass_i |-> (!dest_we_o && !ge_we_o))
    else $error("write enable on failed condition");

  // The shared encoding without the half-form fields writes nothing.
  a_shared_enc: assert property (@(posedge clk_i) disable iff (reset_i)
    (issue_i && op_i == OP_SAT_ORIGIN
     && !(shift_type_i && shift_amt_i == SHAMT_DUAL && packed_ext_i))
    |-> !dest_we_o)
    else $error("plain saturate taken as half form");

  // Reserved destination on a subtract form is reported.
  a_unpred_sub: assert property (@(posedge clk_i) disable iff (reset_i)
    (issue_i && (op_res == OP_DUAL_HALF_SUB)
     && (dest_idx_i == IDX_STACK)) |-> unpred_o)
    else $error("reserved index not reported");

  // Reserved source on the saturate form is reported.
  a_unpred_sat: assert property (@(posedge clk_i) disable iff (reset_i)
    (issue_i && (op_res == OP_DUAL_HALF_SAT)
     && (first_operand_reg_index_i == IDX_PC)) |-> unpred_o)
    else $error("reserved saturate source not reported");
endmodule
`default_nettype wire

// ---- verilog/ussu_pkg.sv ----
// Purpose: Shared constants and types for the unsigned packed subtract unit.
// Assumes: 32-bit operands, 16 architectural register indices.
// Notes:   Operation codes are chosen by the surrounding decoder.
`default_nettype none
package ussu_pkg;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned IDX_W     = 4;
  localparam int unsigned HALF_W    = 16;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned SAT_W     = 4;
  localparam int unsigned ROT_W     = 2;
  localparam int unsigned SHAMT_W   = 5;
  localparam int unsigned GE_W      = 4;
  // Register indices whose use makes an encoding unpredictable.
  localparam logic [3:0] IDX_STACK  = 4'h000d;
  localparam logic [3:0] IDX_PC     = 4'h000f;
  // Shift amount that selects the dual-half saturate form.
  localparam logic [4:0] SHAMT_DUAL = 5'h0_0000;
  // Rotation step in bits per code of the rotation field.
  localparam int unsigned ROT_STEP  = 8;
  // Sum threshold for the exchange add lane carry.
  localparam logic [16:0] SUM_CARRY = 17'h1_0000;
  // Values after reset of the registered outputs.
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [3:0]  GE_RST     = 4'h0000;
  localparam logic        Q_RST      = 1'b0;

  // Operation selected by the decoder.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SAT_ORIGIN,
    OP_DUAL_HALF_SAT,
    OP_XCHG_SUB_ADD,
    OP_DUAL_HALF_SUB,
    OP_QUAD_BYTE_SUB,
    OP_ROT_EXT_ADD
  } ussu_op_type;

  // True when an index is the stack pointer or program counter.
  function automatic logic bad_index(input logic [3:0] idx);
    return (idx == IDX_STACK) || (idx == IDX_PC);
  endfunction
endpackage
`default_nettype wire

// ---- verilog/ussu_lane_if.sv ----
// Purpose: Carries operands and lane results between the top and the
//          lane arithmetic.
// Assumes: Single clock domain, purely combinational signals.
// Notes:   The top drives operands, the lane module drives results.
`default_nettype none
interface ussu_lane_if;
  import ussu_pkg::*;
  logic [31:0] opa;        // First operand value.
  logic [31:0] opb;        // Second operand value.
  logic [3:0]  sat_pos;    // Saturation bit position.
  logic [1:0]  rot_code;   // Rotation field.
  logic [31:0] sat_res;    // Dual-half saturate result.
  logic        sat_hit;    // Either half saturated.
  logic [31:0] xsa_res;    // Exchange subtract/add result.
  logic [3:0]  xsa_ge;     // Exchange lane flags.
  logic [31:0] sub16_res;  // Dual-half difference.
  logic [3:0]  sub16_ge;   // Dual-half lane flags.
  logic [31:0] sub8_res;   // Quad-byte difference.
  logic [3:0]  sub8_ge;    // Quad-byte lane flags.
  logic [31:0] ext_res;    // Rotate, extend and add result.
  modport top  (output opa, opb, sat_pos, rot_code,
                input  sat_res, sat_hit, xsa_res, xsa_ge, sub16_res,
                       sub16_ge, sub8_res, sub8_ge, ext_res);
  modport lane (input  opa, opb, sat_pos, rot_code,
                output sat_res, sat_hit, xsa_res, xsa_ge, sub16_res,
                       sub16_ge, sub8_res, sub8_ge, ext_res);
endinterface
`default_nettype wire

// ---- verilog/ussu_lanes.sv ----
// Purpose: Combinational lane arithmetic for all packed operations.
// Assumes: Operands are stable for the cycle.
// Notes:   Every operation is computed in parallel; the top selects one.
`default_nettype none
module ussu_lanes (
  ussu_lane_if.lane lif
);
  import ussu_pkg::*;

  // Clamp a signed half to 0 .. 2^pos-1; flag when clamping happened.
  function automatic logic [16:0] usat_half(input logic [15:0] v,
                                            input logic [3:0]  pos);
    logic [15:0] maxv;
    maxv = 16'((17'h0_0001 << pos) - 17'h0_0001);
    if (v[15])
      return {1'b1, 16'h0000};
    else if (v > maxv)
      return {1'b1, maxv};
    else
      return {1'b0, v};
  endfunction

  logic [16:0] sat_lo;   // Low half clamp with flag.
  logic [16:0] sat_hi;   // High half clamp with flag.
  logic [16:0] sum_x;    // Exchange sum with carry.
  logic [16:0] dif_x;    // Exchange difference with borrow.
  logic [16:0] dif_lo;   // Low half difference.
  logic [16:0] dif_hi;   // High half difference.
  logic [8:0]  dif_b [4];// Byte differences with borrow.
  logic [31:0] rot;      // Rotated second operand.

  // All lane arithmetic in one combinational process.
  always_comb begin
    sat_lo = usat_half(lif.opa[15:0], lif.sat_pos);
    sat_hi = usat_half(lif.opa[31:16], lif.sat_pos);
    lif.sat_res = {sat_hi[15:0], sat_lo[15:0]};
    lif.sat_hit = sat_lo[16] | sat_hi[16];
    sum_x = {1'b0, lif.opa[15:0]} + {1'b0, lif.opb[31:16]};
    dif_x = {1'b0, lif.opa[31:16]} - {1'b0, lif.opb[15:0]};
    lif.xsa_res = {dif_x[15:0], sum_x[15:0]};
    lif.xsa_ge = {{2{~dif_x[16]}},
                  {2{sum_x >= SUM_CARRY}}};
    dif_lo = {1'b0, lif.opa[15:0]} - {1'b0, lif.opb[15:0]};
    dif_hi = {1'b0, lif.opa[31:16]} - {1'b0, lif.opb[31:16]};
    lif.sub16_res = {dif_hi[15:0], dif_lo[15:0]};
    lif.sub16_ge = {{2{~dif_hi[16]}}, {2{~dif_lo[16]}}};
    // Flag bit i follows byte i; the printed byte three pairing for
    // bit one is taken as a slip.
    for (int i = 0; i < 4; i++) begin
      dif_b[i] = {1'b0, lif.opa[8*i +: 8]} - {1'b0, lif.opb[8*i +: 8]};
      lif.sub8_res[8*i +: 8] = dif_b[i][7:0];
      lif.sub8_ge[i] = ~dif_b[i][8];
    end
    rot = (lif.opb >> (lif.rot_code * ROT_STEP)) |
          (lif.opb << (DATA_W - lif.rot_code * ROT_STEP));
    if (lif.rot_code == 2'b00)
      rot = lif.opb;
    lif.ext_res = lif.opa + {24'h00_0000, rot[7:0]};
  end
endmodule
`default_nettype wire

// ---- verilog/ussu_decode.sv ----
// Purpose: Resolves the shared saturate encoding and checks indices.
// Assumes: The decoder gives a raw operation and the shift fields.
// Notes:   Unpredictable encodings are flagged only, never trapped.
`default_nettype none
module ussu_decode (
  input  wire ussu_pkg::ussu_op_type op_i,
  input  wire logic [3:0]            dest_idx_i,
  input  wire logic [3:0]            first_idx_i,
  input  wire logic [3:0]            second_idx_i,
  input  wire logic                  shift_type_i,
  input  wire logic [4:0]            shift_amt_i,
  input  wire logic                  packed_ext_i,
  output var  ussu_pkg::ussu_op_type op_o,
  output logic                       unpred_o
);
  import ussu_pkg::*;

  // Resolve the operation and flag reserved register use.
  always_comb begin
    op_o = op_i;
    if (op_i == OP_SAT_ORIGIN) begin
      // Only the half form belongs here; the plain form passes on.
      if (shift_type_i && shift_amt_i == SHAMT_DUAL && packed_ext_i)
        op_o = OP_DUAL_HALF_SAT;
      else
        op_o = OP_NONE;
    end
    case (op_o)
      OP_DUAL_HALF_SAT:
        unpred_o = bad_index(dest_idx_i) |
                   bad_index(first_idx_i);
      OP_XCHG_SUB_ADD, OP_DUAL_HALF_SUB, OP_QUAD_BYTE_SUB:
        unpred_o = bad_index(dest_idx_i) | bad_index(first_idx_i) |
                   bad_index(second_idx_i);
      OP_ROT_EXT_ADD:
        unpred_o = bad_index(dest_idx_i) |
                   (first_idx_i == IDX_STACK) |
                   bad_index(second_idx_i);
      default:
        unpred_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- verif/ussu_rf_model.sv ----
// Purpose: Register file that feeds the unit and takes its results.
// Assumes: Two combinational read ports and one write port.
// Notes:   Contents start at zero so that no read is ever unknown.
`default_nettype none
module ussu_rf_model (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  widx_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  ridx_a_i,
  input  wire logic [3:0]  ridx_b_i,
  output logic [31:0]      rdata_a_o,
  output logic [31:0]      rdata_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];  // Architectural registers.

  ////////////////////////////////////////////////////////////////////////
  // Writes land on the edge, so a result is seen one cycle later.
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 32'h0000_0000;
    end
  end
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[widx_i] <= wdata_i;
    end
  end
  assign rdata_a_o = mem[ridx_a_i];
  assign rdata_b_o = mem[ridx_b_i];
endmodule
`default_nettype wire

// ---- verif/unsigned_simd_sub_sat_unit_bench.sv ----
// Purpose: Self-checking bench for the unsigned packed subtract unit.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Table rows first, then refusal, reset and sticky flag cases.
`default_nettype none
module unsigned_simd_sub_sat_unit_bench import ussu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    ussu_op_type op;
    logic [31:0] a, b, res;
    logic [3:0]  ge, pos;
    logic [1:0]  rot;
    logic        gewe;
  } ussu_row_type;
  // Each row: operation, operands, expected word and flags.
  ussu_row_type rows[12] = '{
    '{OP_XCHG_SUB_ADD, 32'h8000_ffff, 32'h0001_0002, 32'h7ffe_0000,
      4'hf, 4'h0, 2'h0, 1'h1},
    '{OP_XCHG_SUB_ADD, 32'h0001_0001, 32'h0000_0002, 32'hffff_0001,
      4'h0, 4'h0, 2'h0, 1'h1},
    '{OP_DUAL_HALF_SUB, 32'h0005_0003, 32'h0005_0004, 32'h0000_ffff,
      4'hc, 4'h0, 2'h0, 1'h1},
    '{OP_DUAL_HALF_SUB, 32'h0000_8000, 32'h0001_7fff, 32'hffff_0001,
      4'h3, 4'h0, 2'h0, 1'h1},
    '{OP_QUAD_BYTE_SUB, 32'h1020_3040, 32'h1121_2f41, 32'hffff_01ff,
      4'h2, 4'h0, 2'h0, 1'h1},
    '{OP_ROT_EXT_ADD, 32'h0000_0100, 32'h4433_2211, 32'h0000_0111,
      4'h0, 4'h0, 2'h0, 1'h0},
    '{OP_ROT_EXT_ADD, 32'h0000_0100, 32'h4433_2211, 32'h0000_0122,
      4'h0, 4'h0, 2'h1, 1'h0},
    '{OP_ROT_EXT_ADD, 32'h0000_0100, 32'h4433_2211, 32'h0000_0133,
      4'h0, 4'h0, 2'h2, 1'h0},
    '{OP_ROT_EXT_ADD, 32'h0000_0100, 32'h4433_2211, 32'h0000_0144,
      4'h0, 4'h0, 2'h3, 1'h0},
    '{OP_ROT_EXT_ADD, 32'hffff_ffff, 32'h0000_0001, 32'h0000_0000,
      4'h0, 4'h0, 2'h0, 1'h0},
    '{OP_DUAL_HALF_SAT, 32'h00ff_0100, 32'h0000_0000, 32'h00ff_00ff,
      4'h0, 4'h8, 2'h0, 1'h0},
    '{OP_DUAL_HALF_SAT, 32'h8000_7fff, 32'h0000_0000, 32'h0000_7fff,
      4'h0, 4'hf, 2'h0, 1'h0}};
  logic clk, reset, issue, cond, st, sa_bit, pe, ld_we, dest_we, ge_we;
  logic sticky, unpred;
  ussu_op_type op;
  logic [3:0]  di, fi, pos, ge, ge_reg, dest_o, ld_idx;
  logic [1:0]  rot;
  logic [31:0] av, bv, result, result_reg, ld_val;
  int          err_count, checks, cycles;

  ////////////////////////////////////////////////////////////////////////
  // The register file takes bench preloads and the unit's write-back.
  ussu_rf_model u_rf (.clk_i(clk), .we_i(ld_we | dest_we),
    .widx_i(ld_we ? ld_idx : dest_o), .wdata_i(ld_we ? ld_val : result),
    .ridx_a_i(fi), .ridx_b_i(4'h2), .rdata_a_o(av), .rdata_b_o(bv));
  ussu_top u_dut (.clk_i(clk), .reset_i(reset), .issue_i(issue),
    .cond_pass_i(cond), .op_i(op), .dest_idx_i(di),
    .first_operand_reg_index_i(fi), .second_operand_reg_index_i(4'h2),
    .first_value_i(av), .second_value_i(bv), .sat_pos_i(pos),
    .rot_code_i(rot), .shift_type_i(st), .shift_amt_i({4'h0, sa_bit}),
    .packed_ext_i(pe), .result_o(result), .dest_idx_o(dest_o),
    .dest_we_o(dest_we), .lane_greater_equal_flags_o(ge),
    .ge_we_o(ge_we), .sticky_saturation_flag_o(sticky),
    .unpred_o(unpred), .result_reg_o(result_reg), .ge_reg_o(ge_reg));

  ////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and shared tasks.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ld(input logic [3:0] idx, input logic [31:0] val);
    @(posedge clk);
    #1 {ld_we, ld_idx, ld_val} = {1'h1, idx, val};
    @(posedge clk);
    #1 ld_we = 1'h0;
  endtask
  // Holds one request mid-cycle so combinational outputs have settled.
  task automatic run(input ussu_op_type o, input logic c,
                     input logic [3:0] d, input logic [3:0] f);
    @(posedge clk);
    #1 {issue, cond, di, fi} = {1'h1, c, d, f};
    op = o;
    #20;
  endtask
  task automatic idle();
    @(posedge clk);
    #1 {issue, cond} = 2'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: table, then refusals, shared encoding and sticky flag.
  initial begin
    {clk, reset, issue, cond, st, sa_bit, pe, ld_we} = 8'h0_0;
    op = OP_NONE;
    {di, fi, pos, rot, ld_idx} = 18'h0_0000;
    ld_val = 32'h0000_0000;
    {reset, st, pe} = 3'h7;
    repeat (5) @(posedge clk);
    chk(32'(sticky), 32'h0000_0000);
    #1 reset = 1'h0;
    foreach (rows[i]) begin
      ld(4'h1, rows[i].a);
      ld(4'h2, rows[i].b);
      {pos, rot} = {rows[i].pos, rows[i].rot};
      run(rows[i].op, 1'h1, 4'h3, 4'h1);
      chk(result, rows[i].res);
      chk(32'(ge_we), 32'(rows[i].gewe));
      if (rows[i].gewe) chk(32'(ge), 32'(rows[i].ge));
      idle();
      chk(result_reg, rows[i].res);
      if (rows[i].gewe) chk(32'(ge_reg), 32'(rows[i].ge));
    end
    chk(32'(sticky), 32'h0000_0001);
    run(OP_DUAL_HALF_SUB, 1'h0, 4'h3, 4'h1);
    chk(32'({dest_we, ge_we}), 32'h0000_0000);
    idle();
    chk(result_reg, 32'h0000_7fff);
    run(OP_DUAL_HALF_SUB, 1'h1, 4'hd, 4'h1);
    chk(32'(unpred), 32'h0000_0001);
    run(OP_DUAL_HALF_SUB, 1'h1, 4'h3, 4'h1);
    chk(32'(unpred), 32'h0000_0000);
    run(OP_DUAL_HALF_SAT, 1'h1, 4'h3, 4'hf);
    chk(32'(unpred), 32'h0000_0001);
    idle();
    sa_bit = 1'h1;
    run(OP_SAT_ORIGIN, 1'h1, 4'h3, 4'h1);
    chk(32'(dest_we), 32'h0000_0000);
    idle();
    sa_bit = 1'h0;
    run(OP_SAT_ORIGIN, 1'h1, 4'h3, 4'h1);
    chk(32'(dest_we), 32'h0000_0001);
    idle();
    reset = 1'h1;
    #2 chk({sticky, ge_reg, result_reg[26:0]}, 32'h0000_0000);
    @(posedge clk);
    #1 reset = 1'h0;
    pos = 4'h0;
    for (int k = 0; k < 3; k++) begin
      ld(4'h1, (k == 1) ? 32'h0000_0001 : 32'h0000_0000);
      run(OP_DUAL_HALF_SAT, 1'h1, 4'h3, 4'h1);
      chk(result, 32'h0000_0000);
      idle();
      chk(32'(sticky), (k == 0) ? 32'h0000_0000 : 32'h0000_0001);
    end
    finish_test();
  end
endmodule
`default_nettype wire
